// ==== rtl/swic_consts.svh ====
// Constants for the sleep and wake-up controller
`ifndef SWIC_CONSTS_SVH
`define SWIC_CONSTS_SVH
`define SWIC_OST_PERIODS    1024
`define SWIC_VECTOR_ADDR    13'h0004
`define SWIC_OSC_PER_INSN   4
`define SWIC_DUMMY_CYCLES   2
`define SWIC_EXPIRY_RST     1'b1
`define SWIC_SLEEP_RST      1'b1
`endif

// ==== rtl/swic_pkg.sv ====
// Types for the sleep and wake-up controller
package swic_pkg;
  typedef enum logic [2:0] {
    SWIC_AWAKE  = 3'b000,
    SWIC_ASLEEP = 3'b001,
    SWIC_OST    = 3'b010,
    SWIC_POST   = 3'b011,
    SWIC_DUMMY  = 3'b100
  } swic_state_t;
  typedef enum logic [1:0] {
    SWIC_OSC_CRYSTAL = 2'b00,
    SWIC_OSC_EXT     = 2'b01,
    SWIC_OSC_RC      = 2'b10
  } swic_osc_t;
endpackage

// ==== rtl/swic_ctrl.sv ====
// Sleep entry and interrupt wake-up sequencer
`timescale 1ns/1ns
`include "swic_consts.svh"
module swic_ctrl
  import swic_pkg::*;
#(
  parameter int NUM_SRC     = 8,
  parameter int OST_PERIODS = `SWIC_OST_PERIODS
) (
  input  wire logic               clock_i,
  input  wire logic               nrst_i,
  input  wire logic               sleep_insn_i,
  input  wire logic               watchdog_clear_instruction_i,
  input  wire logic               watchdog_timeout_i,
  input  wire logic               global_interrupt_enable_i,
  input  wire logic [NUM_SRC-1:0] irq_enable_i,
  input  wire logic [NUM_SRC-1:0] irq_flag_i,
  input  wire logic [1:0]         osc_mode_i,
  output logic                    watchdog_clear_o,
  output logic                    watchdog_expiry_flag_o,
  output logic                    sleep_entered_flag_o,
  output logic                    osc_driver_on_o,
  output logic                    io_hold_o,
  output logic                    core_stall_o,
  output logic                    exec_post_sleep_o,
  output logic                    dummy_cycle_o,
  output logic                    vector_load_o,
  output logic [12:0]             vector_addr_o
);

  // Oscillator periods counted in oscillator ticks, one per clock
  localparam int OSTW = $clog2(OST_PERIODS + 1);

  // Refuse sizes the request vector and start-up counter cannot serve
  if (NUM_SRC < 1) begin : g_bad_src
    $error("swic_ctrl: NUM_SRC must be at least 1");
  end
  if (OST_PERIODS < 1) begin : g_bad_ost
    $error("swic_ctrl: OST_PERIODS must be at least 1");
  end

  swic_state_t      state_reg, state_next;
  logic [OSTW-1:0]  ost_cnt_reg, ost_cnt_next;
  logic             dummy_cnt_reg, dummy_cnt_next;
  logic             vec_pend_reg, vec_pend_next;
  logic             expiry_reg, expiry_next;
  logic             sleepf_reg, sleepf_next;
  logic             wdclr_reg, wdclr_next;
  logic             post_reg, post_next;
  logic             dummy_reg, dummy_next;
  logic             vload_reg, vload_next;

  // Per-source wake request: own enable and flag, global bit ignored
  wire logic [NUM_SRC-1:0] src_req;
  for (genvar s = 0; s < NUM_SRC; s++) begin : g_src
    assign src_req[s] = irq_enable_i[s] & irq_flag_i[s];
  end

  // Wake causes seen while asleep
  wire logic irq_pending  = |src_req;
  wire logic wake_now     = irq_pending | watchdog_timeout_i;
  wire logic tmo_only     = watchdog_timeout_i & ~irq_pending;

  // Start-up delay counted only in the crystal mode
  wire logic crystal_mode = (osc_mode_i == SWIC_OSC_CRYSTAL);
  wire logic ost_done     = (ost_cnt_reg == OSTW'(OST_PERIODS - 1));

  // Next-state decodes feeding the registered power controls
  wire logic next_asleep  = (state_next == SWIC_ASLEEP);
  wire logic next_ost     = (state_next == SWIC_OST);
  wire logic next_awake   = (state_next == SWIC_AWAKE);

  // Sequencer next state
  always_comb begin
    state_next     = state_reg;
    ost_cnt_next   = ost_cnt_reg;
    dummy_cnt_next = dummy_cnt_reg;
    vec_pend_next  = vec_pend_reg;
    expiry_next    = expiry_reg;
    sleepf_next    = sleepf_reg;
    wdclr_next     = watchdog_clear_instruction_i;
    post_next      = 1'b0;
    dummy_next     = 1'b0;
    vload_next     = 1'b0;
    case (state_reg)
      SWIC_AWAKE: begin
        if (sleep_insn_i && irq_pending) begin
          // Pending before sleep: no-op, nothing touched
          state_next = SWIC_AWAKE;
        end else if (sleep_insn_i) begin
          // Sleep completes fully; an irq arriving from the next cycle on wakes it
          wdclr_next  = 1'b1;
          sleepf_next = 1'b0;
          expiry_next = 1'b1;
          state_next  = SWIC_ASLEEP;
        end
      end
      SWIC_ASLEEP: begin
        if (wake_now) begin
          wdclr_next    = 1'b1;
          vec_pend_next = global_interrupt_enable_i & irq_pending;
          // Watchdog wake alone clears expiry; an interrupt wins
          if (tmo_only) begin
            expiry_next = 1'b0;
          end
          // Start-up count restarts on every wake
          ost_cnt_next = '0;
          state_next   = crystal_mode ? SWIC_OST : SWIC_POST;
        end
      end
      SWIC_OST: begin
        // Watchdog held clear while the start-up count runs
        wdclr_next = 1'b1;
        if (ost_done) begin
          state_next = SWIC_POST;
        end else begin
          ost_cnt_next = ost_cnt_reg + OSTW'(1);
        end
      end
      SWIC_POST: begin
        // Instruction after sleep always runs before any vector
        post_next = 1'b1;
        if (vec_pend_reg) begin
          dummy_cnt_next = 1'b0;
          state_next     = SWIC_DUMMY;
        end else begin
          state_next = SWIC_AWAKE;
        end
      end
      SWIC_DUMMY: begin
        // Two dummy cycles, vector fetched during the second
        dummy_next = 1'b1;
        if (dummy_cnt_reg) begin
          vload_next    = 1'b1;
          vec_pend_next = 1'b0;
          state_next    = SWIC_AWAKE;
        end else begin
          dummy_cnt_next = 1'b1;
        end
      end
      default: begin
        state_next = SWIC_AWAKE;
      end
    endcase
  end

  // Sequencer state and counters
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg     <= SWIC_AWAKE;
      ost_cnt_reg   <= '0;
      dummy_cnt_reg <= 1'b0;
      vec_pend_reg  <= 1'b0;
    end else begin
      state_reg     <= state_next;
      ost_cnt_reg   <= ost_cnt_next;
      dummy_cnt_reg <= dummy_cnt_next;
      vec_pend_reg  <= vec_pend_next;
    end
  end

  // Status flags; both read as set after reset
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      expiry_reg <= `SWIC_EXPIRY_RST;
      sleepf_reg <= `SWIC_SLEEP_RST;
    end else begin
      expiry_reg <= expiry_next;
      sleepf_reg <= sleepf_next;
    end
  end

  // Registered strobes to the watchdog and the core; clear spans the start-up count, dummy two cycles
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wdclr_reg <= 1'b0;
      post_reg  <= 1'b0;
      dummy_reg <= 1'b0;
      vload_reg <= 1'b0;
    end else begin
      wdclr_reg <= wdclr_next;
      post_reg  <= post_next;
      dummy_reg <= dummy_next;
      vload_reg <= vload_next;
    end
  end

  // Registered power and core controls; oscillator off only in sleep
  // Pins stay held through the start-up count as well
  logic osc_reg;
  logic hold_reg;
  logic stall_reg;
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      osc_reg   <= 1'b1;
      hold_reg  <= 1'b0;
      stall_reg <= 1'b0;
    end else begin
      osc_reg   <= ~next_asleep;
      hold_reg  <= next_asleep | next_ost;
      stall_reg <= ~next_awake;
    end
  end

  // Vector address kept in a flop so every output is registered
  logic [12:0] vaddr_reg;
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      vaddr_reg <= `SWIC_VECTOR_ADDR;
    end else begin
      vaddr_reg <= `SWIC_VECTOR_ADDR;
    end
  end

  // Outputs straight from their flops
  assign watchdog_clear_o       = wdclr_reg;
  assign watchdog_expiry_flag_o = expiry_reg;
  assign sleep_entered_flag_o   = sleepf_reg;
  assign osc_driver_on_o        = osc_reg;
  assign io_hold_o              = hold_reg;
  assign core_stall_o           = stall_reg;
  assign exec_post_sleep_o      = post_reg;
  assign dummy_cycle_o          = dummy_reg;
  assign vector_load_o          = vload_reg;
  assign vector_addr_o          = vaddr_reg;

endmodule // swic_ctrl

// ==== verif/swic_core_model.sv ====
// Core model: watchdog clear, then sleep
`timescale 1ns/1ns
module swic_core_model (
  input  wire logic clock_i,
  input  wire logic go_i,
  output logic      clr_o = 1'b0,
  output logic      sleep_o = 1'b0
);
  // Clear first so a skipped sleep still clears the watchdog
  always @(posedge clock_i) begin
    clr_o <= go_i;
    sleep_o <= clr_o;
  end
endmodule // swic_core_model

// ==== verif/swic_ctrl_checker.sv ====
// Assertions on the sleep sequencer ports
`timescale 1ns/1ns
module swic_ctrl_checker #(parameter int NUM_SRC = 8, OST_PERIODS = 8) (
  input logic clock_i, nrst_i, sleep_insn_i, watchdog_timeout_i,
  input logic global_interrupt_enable_i, watchdog_clear_o, core_stall_o,
  input logic [NUM_SRC-1:0] irq_enable_i, irq_flag_i,
  input logic [1:0] osc_mode_i,
  input logic watchdog_expiry_flag_o, sleep_entered_flag_o,
  input logic osc_driver_on_o, exec_post_sleep_o, dummy_cycle_o,
  input logic vector_load_o, io_hold_o,
  input logic [12:0] vector_addr_o
);
  // Pending request, dormant state, wake event
  wire pend = |(irq_enable_i & irq_flag_i);
  wire zz = core_stall_o && !osc_driver_on_o;
  wire wake = zz && (pend || watchdog_timeout_i);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  sequence s_vec; dummy_cycle_o ##1 dummy_cycle_o && vector_load_o;
  endsequence
  property p_noop; !core_stall_o && sleep_insn_i && pend |=> !core_stall_o
    && !watchdog_clear_o && $stable(sleep_entered_flag_o); endproperty
  a_noop: assert property (p_noop) else $error("no-op");
  property p_sleep; !core_stall_o && sleep_insn_i && !pend |=> zz
    && watchdog_clear_o && watchdog_expiry_flag_o && !sleep_entered_flag_o;
  endproperty
  a_sleep: assert property (p_sleep) else $error("entry");
  property p_hold; zz && !pend && !watchdog_timeout_i |=> zz; endproperty
  a_hold: assert property (p_hold) else $error("woke");
  property p_wake; wake |=> watchdog_clear_o && osc_driver_on_o; endproperty
  a_wake: assert property (p_wake) else $error("clear");
  property p_ost; wake && osc_mode_i == 2'h0
    |=> watchdog_clear_o [*8] ##[1:2] exec_post_sleep_o; endproperty
  a_ost: assert property (p_ost) else $error("delay");
  property p_fast; wake && osc_mode_i != 2'h0 |-> ##2 exec_post_sleep_o;
  endproperty
  a_fast: assert property (p_fast) else $error("resume");
  property p_vec; exec_post_sleep_o && global_interrupt_enable_i && pend
    |=> s_vec ##1 !core_stall_o; endproperty
  a_vec: assert property (p_vec) else $error("vector");
  property p_line; exec_post_sleep_o && !global_interrupt_enable_i
    |=> !core_stall_o && !dummy_cycle_o; endproperty
  a_line: assert property (p_line) else $error("inline");
  property p_iohold; zz |-> io_hold_o; endproperty
  a_iohold: assert property (p_iohold) else $error("hold");
  property p_vaddr; vector_load_o |-> vector_addr_o == 13'h0004; endproperty
  a_vaddr: assert property (p_vaddr) else $error("address");
endmodule // swic_ctrl_checker
bind swic_ctrl swic_ctrl_checker
  #(.NUM_SRC(NUM_SRC), .OST_PERIODS(OST_PERIODS)) u_chk (.*);

// ==== verif/swic_ctrl_tb.sv ====
// Self-checking bench for the sleep sequencer
`timescale 1ns/1ns
module swic_ctrl_tb;
  logic clock_i = 1'b0, nrst_i = 1'b0, go = 1'b0, probe = 1'b0;
  logic sleep_insn_i, watchdog_clear_instruction_i;
  logic exp_sleep = 1'b1, exp_expiry = 1'b1;
  logic watchdog_timeout_i = 1'b0, global_interrupt_enable_i = 1'b0;
  logic [7:0] irq_enable_i = 8'h00, irq_flag_i = 8'h00;
  logic [1:0] osc_mode_i = 2'h0;
  logic watchdog_clear_o, watchdog_expiry_flag_o, sleep_entered_flag_o;
  logic osc_driver_on_o, io_hold_o, core_stall_o, exec_post_sleep_o;
  logic dummy_cycle_o, vector_load_o;
  logic [12:0] vector_addr_o;
  logic [16:0] lf = 17'h112fa;
  logic [2:0] notes[$];
  int error_cnt = 0, checks_done = 0;
  swic_ctrl #(.OST_PERIODS(8)) uut (.*);
  swic_core_model core (.clock_i(clock_i), .go_i(go),
    .clr_o(watchdog_clear_instruction_i), .sleep_o(sleep_insn_i));
  always #10 clock_i = ~clock_i;
  function automatic logic [16:0] nx(logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  task automatic cyc(int n);
    repeat (n) @(posedge clock_i);
    #2;
  endtask
  task automatic cmp(string nm, logic [2:0] e, logic [2:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s exp %b got %b", nm, e, g);
    end
  endtask
  task automatic conclude;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Flags after a skipped sleep or at the post-sleep step
  logic [2:0] want, seen;
  always @(negedge clock_i) begin
    if (exec_post_sleep_o === 1'b1 || probe) begin
      want = notes.size() ? notes.pop_front() : 3'h7;
      seen = {sleep_entered_flag_o, watchdog_expiry_flag_o, core_stall_o};
      cmp("flags", want, seen);
    end
  end
  // One sleep attempt; a pending request makes it a no-op
  task automatic nap(bit skip, bit by_tmo);
    lf = nx(lf);
    irq_enable_i = lf[7:0] & 8'h7f | 8'h01;
    irq_flag_i = skip ? irq_enable_i : 8'h80;
    go = 1'b1;
    cyc(1);
    go = 1'b0;
    cyc(5);
    notes.push_back(skip ? {exp_sleep, exp_expiry, 1'b0}
      : {1'b0, !by_tmo, global_interrupt_enable_i & !by_tmo});
    if (skip) probe = 1'b1;
    else if (by_tmo) watchdog_timeout_i = 1'b1;
    else irq_flag_i = 8'h81;
    cyc(1);
    probe = 1'b0;
    repeat (30) if (core_stall_o !== 1'b0) cyc(1);
    {watchdog_timeout_i, irq_flag_i} = 9'h0;
    if (!skip) {exp_sleep, exp_expiry} = {1'b0, !by_tmo};
    cyc(2);
  endtask
  initial begin
    cyc(2);
    nrst_i = 1'b1;
    for (int i = 0; i < 6; i++) begin
      osc_mode_i = 2'(i % 3);
      global_interrupt_enable_i = i > 2;
      nap(1, 0);
      nap(0, 0);
    end
    nap(0, 1);
    conclude();
  end
  // Cut a hang short
  initial begin
    #100000;
    error_cnt++;
    conclude();
  end
endmodule // swic_ctrl_tb
